// [design/ps_cfg.svh]
// Timing and sizing constants for the passive serial configuration port.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef PS_CFG_SVH
`define PS_CFG_SVH
`define PS_CLK_PERIOD_NS      10
`define PS_POR_DELAY_US       2
`define PS_POR_CYCLES         ((`PS_POR_DELAY_US * 1000) / `PS_CLK_PERIOD_NS)
`define PS_STATUS_LOW_US      2
`define PS_STATUS_LOW_CYCLES  ((`PS_STATUS_LOW_US * 1000) / `PS_CLK_PERIOD_NS)
`define PS_INIT_TIME_US       3
`define PS_INIT_CYCLES        ((`PS_INIT_TIME_US * 1000) / `PS_CLK_PERIOD_NS)
`define PS_INIT_FALL_EDGES    2
`define PS_STREAM_BYTES       16
`define PS_SYNC_WORD          8'h6A
`define PS_CNT_W              20
`endif

// [design/ps_pkg.sv]
// Types shared by the passive serial configuration port.
// No dependencies.
package ps_pkg;
  typedef enum logic [2:0] {
    ST_POR,
    ST_STATUS_LOW,
    ST_WAIT_ENABLE,
    ST_LOAD,
    ST_DONE_WAIT,
    ST_INIT,
    ST_USER
  } cfg_state_t;

  typedef struct packed {
    logic restart_n;
    logic status_n;
    logic done;
    logic chip_enable_n;
    logic serial_load_clock;
    logic data0;
  } pin_in_t;

  typedef struct packed {
    logic status_oe;
    logic done_oe;
    logic init_complete;
    logic chain_enable_n;
    logic user_mode;
    logic weak_pullup_en;
    logic data0_oe;
  } pin_out_t;
endpackage : ps_pkg

// [design/ps_sync_edge.sv]
// Two-stage synchroniser with rise and fall detection for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module ps_sync_edge (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'h0;
      stage2 <= 1'h0;
      stage3 <= 1'h0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;
endmodule : ps_sync_edge

// [design/passive_serial_config_port.sv]
// Passive serial configuration port: receives a byte stream LSB first on
// the serial data pin, clocked by the host's serial_load_clock.
// Assumes shared open-drain status and done lines resolved outside.
//
// Functional notes
// - Device samples serial data on each rising serial_load_clock edge.
// - Host clocks until done rises and for two falling edges after; device then enters init.
// - Device releases init-complete high after init and enters user mode.
// - User mode removes weak pull-ups from user pins.
// - Serial data pin stays high impedance in user mode.
// - Clock may stop for any time; loading resumes without loss.
// - Finished device drives chain-enable low; next accepts data at once.
// - Shared done lines make all devices initialise together.
// - Detected error pulls shared status low, resetting the chain.
// - Broadcast devices with enables low start and finish together.
// - User mode holds lines high; restart low begins new cycle.
// - Status held low during power-on reset delay.
`timescale 1ns/1ps
`include "ps_cfg.svh"
module passive_serial_config_port (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire ps_pkg::pin_in_t  pins_in,
  output ps_pkg::pin_out_t  pins_out,
  output logic [7:0]        load_byte,
  output logic              load_byte_valid,
  output logic              load_error
);
  logic restart_lvl;
  logic restart_rise;
  logic restart_fall;
  logic status_lvl;
  logic done_lvl;
  logic ce_lvl;
  logic clk_rise;
  logic clk_fall;
  logic data_lvl;

  ps_sync_edge u_restart (.clk(core_clk), .rst(rst), .pin(pins_in.restart_n),
    .level(restart_lvl), .rise(restart_rise), .fall(restart_fall));
  ps_sync_edge u_status (.clk(core_clk), .rst(rst), .pin(pins_in.status_n),
    .level(status_lvl), .rise(), .fall());
  ps_sync_edge u_done (.clk(core_clk), .rst(rst), .pin(pins_in.done),
    .level(done_lvl), .rise(), .fall());
  ps_sync_edge u_ce (.clk(core_clk), .rst(rst), .pin(pins_in.chip_enable_n),
    .level(ce_lvl), .rise(), .fall());
  ps_sync_edge u_sclk (.clk(core_clk), .rst(rst), .pin(pins_in.serial_load_clock),
    .level(), .rise(clk_rise), .fall(clk_fall));
  ps_sync_edge u_data (.clk(core_clk), .rst(rst), .pin(pins_in.data0),
    .level(data_lvl), .rise(), .fall());

  ps_pkg::cfg_state_t      state;
  ps_pkg::cfg_state_t      next_state;
  logic [`PS_CNT_W-1:0]    timer;
  logic [`PS_CNT_W-1:0]    next_timer;
  logic [7:0]              shift;
  logic [7:0]              next_shift;
  logic [2:0]              bit_cnt;
  logic [2:0]              next_bit_cnt;
  logic [15:0]             byte_cnt;
  logic [15:0]             next_byte_cnt;
  logic [1:0]              fall_cnt;
  logic [1:0]              next_fall_cnt;
  logic                    err;
  logic                    next_err;
  logic [7:0]              out_byte;
  logic [7:0]              next_out_byte;
  logic                    out_valid;
  logic                    next_out_valid;
  logic                    own_done;
  logic                    next_own_done;

  localparam logic [`PS_CNT_W-1:0] POR_CYC  = `PS_CNT_W'(`PS_POR_CYCLES);
  localparam logic [`PS_CNT_W-1:0] STL_CYC  = `PS_CNT_W'(`PS_STATUS_LOW_CYCLES);
  localparam logic [`PS_CNT_W-1:0] INIT_CYC = `PS_CNT_W'(`PS_INIT_CYCLES);
  localparam logic [15:0]          LAST_BYTE = 16'(`PS_STREAM_BYTES - 1);

  always_comb begin
    next_state     = state;
    next_timer     = timer;
    next_shift     = shift;
    next_bit_cnt   = bit_cnt;
    next_byte_cnt  = byte_cnt;
    next_fall_cnt  = fall_cnt;
    next_err       = err;
    next_out_byte  = out_byte;
    next_out_valid = 1'h0;
    next_own_done  = own_done;
    unique case (state)
      ps_pkg::ST_POR: begin
        next_timer = timer + `PS_CNT_W'(1);
        if (timer >= POR_CYC) begin
          next_state = ps_pkg::ST_WAIT_ENABLE;
          next_timer = '0;
        end
      end
      ps_pkg::ST_STATUS_LOW: begin
        next_timer = timer + `PS_CNT_W'(1);
        if (timer >= STL_CYC && restart_lvl) begin
          next_state = ps_pkg::ST_WAIT_ENABLE;
          next_timer = '0;
          next_err   = 1'h0;
        end
      end
      ps_pkg::ST_WAIT_ENABLE: begin
        next_own_done = 1'h0;
        next_bit_cnt  = 3'h0;
        next_byte_cnt = 16'h0;
        if (!ce_lvl && status_lvl)
          next_state = ps_pkg::ST_LOAD;
      end
      ps_pkg::ST_LOAD: begin
        if (clk_rise) begin
          next_shift   = {data_lvl, shift[7:1]};
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            next_out_byte  = {data_lvl, shift[7:1]};
            next_out_valid = 1'h1;
            next_byte_cnt  = byte_cnt + 16'h1;
            if (byte_cnt == 16'h0 && {data_lvl, shift[7:1]} != `PS_SYNC_WORD) begin
              next_err   = 1'h1;
              next_state = ps_pkg::ST_STATUS_LOW;
              next_timer = '0;
            end else if (byte_cnt == LAST_BYTE) begin
              next_own_done = 1'h1;
              next_state    = ps_pkg::ST_DONE_WAIT;
              next_fall_cnt = 2'h0;
            end
          end
        end
      end
      ps_pkg::ST_DONE_WAIT: begin
        if (done_lvl && clk_fall) begin
          next_fall_cnt = fall_cnt + 2'h1;
          if (fall_cnt == 2'(`PS_INIT_FALL_EDGES - 1)) begin
            next_state = ps_pkg::ST_INIT;
            next_timer = '0;
          end
        end
      end
      ps_pkg::ST_INIT: begin
        next_timer = timer + `PS_CNT_W'(1);
        if (timer >= INIT_CYC)
          next_state = ps_pkg::ST_USER;
      end
      ps_pkg::ST_USER: begin
      end
    endcase
    if (restart_fall) begin
      next_state    = ps_pkg::ST_STATUS_LOW;
      next_timer    = '0;
      next_own_done = 1'h0;
      next_err      = 1'h0;
    end else if (state != ps_pkg::ST_POR && state != ps_pkg::ST_STATUS_LOW && !status_lvl
                 && state != ps_pkg::ST_WAIT_ENABLE && state != ps_pkg::ST_USER) begin
      next_state    = ps_pkg::ST_STATUS_LOW;
      next_timer    = '0;
      next_own_done = 1'h0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state     <= ps_pkg::ST_POR;
      timer     <= '0;
      shift     <= 8'h00;
      bit_cnt   <= 3'h0;
      byte_cnt  <= 16'h0000;
      fall_cnt  <= 2'h0;
      err       <= 1'h0;
      out_byte  <= 8'h00;
      out_valid <= 1'h0;
      own_done  <= 1'h0;
    end else begin
      state     <= next_state;
      timer     <= next_timer;
      shift     <= next_shift;
      bit_cnt   <= next_bit_cnt;
      byte_cnt  <= next_byte_cnt;
      fall_cnt  <= next_fall_cnt;
      err       <= next_err;
      out_byte  <= next_out_byte;
      out_valid <= next_out_valid;
      own_done  <= next_own_done;
    end
  end

  ps_pkg::pin_out_t next_pins;

  always_comb begin
    next_pins                = '0;
    next_pins.status_oe      = (state == ps_pkg::ST_POR)
                               || (state == ps_pkg::ST_STATUS_LOW);
    next_pins.done_oe        = !own_done && state != ps_pkg::ST_USER
                               && state != ps_pkg::ST_INIT;
    next_pins.init_complete  = (state == ps_pkg::ST_USER);
    next_pins.chain_enable_n = !own_done && state != ps_pkg::ST_INIT
                               && state != ps_pkg::ST_USER;
    next_pins.user_mode      = (state == ps_pkg::ST_USER);
    next_pins.weak_pullup_en = (state != ps_pkg::ST_USER);
    next_pins.data0_oe       = 1'h0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins_out <= '{status_oe: 1'h1, done_oe: 1'h1, init_complete: 1'h0,
                    chain_enable_n: 1'h1, user_mode: 1'h0, weak_pullup_en: 1'h1,
                    data0_oe: 1'h0};
    end else begin
      pins_out <= next_pins;
    end
  end

  assign load_byte       = out_byte;
  assign load_byte_valid = out_valid;
  assign load_error      = err;
endmodule : passive_serial_config_port

// [testbench/passive_serial_config_port_sva.sv]
// Checker for the configuration port pins.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module passive_serial_config_port_sva (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire ps_pkg::pin_in_t  pins_in,
  input wire ps_pkg::pin_out_t pins_out,
  input wire logic [7:0]       load_byte,
  input wire logic             load_byte_valid,
  input wire logic             load_error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_DATA_TRI: assert property (pins_out.data0_oe == 1'b0)
    else $error("data pin driven");
  AST_POR_HOLD: assert property ($fell(rst) |-> pins_out.status_oe [*8])
    else $error("status released early");
  AST_PULLUP_OFF: assert property (pins_out.user_mode |-> !pins_out.weak_pullup_en)
    else $error("pull-ups on in user mode");
  AST_INIT_USER: assert property ($rose(pins_out.user_mode) |-> pins_out.init_complete)
    else $error("user mode without init complete");
  AST_CHAIN_HAND: assert property ($fell(pins_out.done_oe) |-> ##[0:2] !pins_out.chain_enable_n)
    else $error("chain enable not passed on");
  AST_DONE_CLEAN: assert property ($fell(pins_out.done_oe) |-> !load_error)
    else $error("done released after error");
  AST_RESTART: assert property ($fell(pins_in.restart_n) |->
    ##[1:6] (pins_out.status_oe && pins_out.done_oe))
    else $error("restart not honoured");
  AST_ERR_PULL: assert property ($rose(load_error) |-> ##[0:4] pins_out.status_oe)
    else $error("error without status pull");
  AST_VALID_PULSE: assert property (load_byte_valid |=> !load_byte_valid)
    else $error("valid longer than one cycle");
endmodule : passive_serial_config_port_sva

bind passive_serial_config_port passive_serial_config_port_sva chk (
  .core_clk(core_clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out),
  .load_byte(load_byte), .load_byte_valid(load_byte_valid), .load_error(load_error));

// [testbench/ps_host_model.sv]
// Behavioural host: restart, serial clock and data.
// Assumes 100 MHz core_clk; serial clock 80 ns, parked low between bytes.
`timescale 1ns/1ps
module ps_host_model (
  input  wire logic core_clk,
  output logic      restart_n,
  output logic      serial_load_clock,
  output logic      data0
);
  initial begin
    restart_n         = 1'b1;
    serial_load_clock = 1'b0;
    data0             = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic restart();
    restart_n <= 1'b0;
    tick(60);
    restart_n <= 1'b1;
  endtask : restart
  // One byte, LSB first, one bit per 80 ns clock
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      data0             <= b[i];
      serial_load_clock <= 1'b0;
      tick(4);
      serial_load_clock <= 1'b1;
      tick(4);
    end
    serial_load_clock <= 1'b0;
    data0             <= ~b[7];
  endtask : send_byte
  task automatic fall_pair();
    repeat (2) begin
      serial_load_clock <= 1'b1;
      tick(4);
      serial_load_clock <= 1'b0;
      tick(4);
    end
  endtask : fall_pair
endmodule : ps_host_model

// [testbench/test_passive_serial_config_port.sv]
// Self-checking bench for the configuration port.
// Assumes the design, package and host model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
`define WAITC(c) begin for (int k = 0; k < 3000 && !(c); k++) @(posedge core_clk); \
  `CHK("wait", 1'b1, (c)) end
module test_passive_serial_config_port;
  logic              core_clk = 1'b0;
  logic              rst      = 1'b1;
  logic              chip_enable_n = 1'b0;
  logic              err_pull = 1'b0;
  logic              restart_n, serial_load_clock, data0, load_byte_valid, load_error;
  logic [7:0]        load_byte, exp_b;
  logic [7:0]        exp_q[$];
  ps_pkg::pin_in_t   pins_in;
  ps_pkg::pin_out_t  pins_out;
  int                fails = 0;
  int                n_checks = 0;
  always #5 core_clk = ~core_clk;
  assign pins_in = {restart_n, !pins_out.status_oe && !err_pull, !pins_out.done_oe,
                    chip_enable_n, serial_load_clock, data0};
  ps_host_model host (.core_clk(core_clk), .restart_n(restart_n),
    .serial_load_clock(serial_load_clock), .data0(data0));
  passive_serial_config_port DUT (.core_clk(core_clk), .rst(rst), .pins_in(pins_in),
    .pins_out(pins_out), .load_byte(load_byte), .load_byte_valid(load_byte_valid),
    .load_error(load_error));
  always @(posedge core_clk)
    if (load_byte_valid === 1'b1) begin
      exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
      `CHK("load_byte", exp_b, load_byte)
    end
  task automatic load(input logic [7:0] first, input int n);
    logic [7:0] b;
    `WAITC(pins_out.status_oe === 1'b0)
    host.tick(200);
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? first : 8'($urandom);
      exp_q.push_back(b);
      host.tick(1 + $urandom % 20);
      host.send_byte(b);
    end
    host.tick(8);
  endtask : load
  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    #300us;
    fails++;
    results();
  end
  initial begin
    void'($urandom(32'h45F2));
    host.tick(8);
    rst <= 1'b0;
    host.tick(2);
    `CHK("status_oe", 1'b1, pins_out.status_oe)
    `CHK("done_oe", 1'b1, pins_out.done_oe)
    load(8'h6A, 16);
    `CHK("done_oe", 1'b0, pins_out.done_oe)
    `CHK("chain_enable_n", 1'b0, pins_out.chain_enable_n)
    host.fall_pair();
    `WAITC(pins_out.user_mode === 1'b1)
    `CHK("init_complete", 1'b1, pins_out.init_complete)
    `CHK("weak_pullup_en", 1'b0, pins_out.weak_pullup_en)
    host.restart();
    `CHK("status_oe", 1'b1, pins_out.status_oe)
    load(8'h00, 1);
    `CHK("load_error", 1'b1, load_error)
    `CHK("status_oe", 1'b1, pins_out.status_oe)
    exp_q.delete();
    host.restart();
    load(8'h6A, 3);
    err_pull <= 1'b1;
    host.tick(10);
    err_pull <= 1'b0;
    `CHK("status_oe", 1'b1, pins_out.status_oe)
    `CHK("done_oe", 1'b1, pins_out.done_oe)
    exp_q.delete();
    chip_enable_n <= 1'b1;
    host.restart();
    `WAITC(pins_out.status_oe === 1'b0)
    host.tick(200);
    host.send_byte(8'h6A);
    host.tick(8);
    `CHK("done_oe", 1'b1, pins_out.done_oe)
    chip_enable_n <= 1'b0;
    load(8'h6A, 16);
    `CHK("done_oe", 1'b0, pins_out.done_oe)
    results();
  end
endmodule : test_passive_serial_config_port
